// [sfd_space.sv]
// Special function register space with data pointer and core registers
// Functional notes
// [RULE1] Direct accesses 0x80 to 0xFF reach registers
// [RULE2] Addresses ending 0 or 8 allow bits
// [RULE3] Other registers byte access only
// [RULE4] Core avoids unoccupied, reserved addresses
// [RULE5] Reserved bits stay zero after reset
// [RULE6] Data pointer low at 0x82, resets zero
// [RULE7] Data pointer high at 0x83, resets zero
// [RULE8] Data pointer addresses flash and external RAM
// [RULE9] Indirect upper addresses go to upper RAM
// [RULE10] Stack pointer resets seven, pre-increment push
// [RULE11] Bit address selects byte and bit position
`default_nettype none
module sfd_space (
  input wire logic clock,
  input wire logic reset,
  input wire sfd_pkg::sfd_req_t req,
  output sfd_pkg::sfd_rsp_t rsp,
  output logic [15:0] data_pointer_16,
  output logic [7:0] stack_pointer
);
  import sfd_pkg::*;

  sfd_state_t state, next_state;

  // -----------------------------------------------------------------
  // Decoding
  // -----------------------------------------------------------------
  function automatic logic bit_capable(input logic [7:0] a);
    return a[2:0] == 3'h0;
  endfunction

  function automatic logic occupied(input logic [7:0] a);
    return a == ADDR_STACK_POINTER || a == ADDR_DATA_POINTER_LOW ||
           a == ADDR_DATA_POINTER_HIGH || a == ADDR_STATUS_WORD ||
           a == ADDR_ACCUMULATOR || a == ADDR_SECOND_ACCUMULATOR;
  endfunction

  logic [7:0] byte_addr;
  logic [2:0] bit_pos;
  logic in_sfr;
  logic valid_acc;
  logic [7:0] cur;
  logic [7:0] upd;
  logic parity;

  always_comb begin
    bit_pos = req.addr[2:0];
    // Bit space above 0x7F maps onto the aligned register
    byte_addr = req.bit_mode ? {req.addr[7:3], 3'h0} : req.addr; // RULE11
    in_sfr = !req.indirect && byte_addr[7]; // RULE1 RULE9
    // Bit accesses to unaligned registers are never decoded
    valid_acc = in_sfr && occupied(byte_addr) &&
                (!req.bit_mode || bit_capable(byte_addr)); // RULE2 RULE3
    unique case (byte_addr)
      ADDR_STACK_POINTER: cur = state.stack_pointer;
      ADDR_DATA_POINTER_LOW: cur = state.data_pointer_low;
      ADDR_DATA_POINTER_HIGH: cur = state.data_pointer_high;
      ADDR_STATUS_WORD: cur = state.program_status_word;
      ADDR_ACCUMULATOR: cur = state.accumulator;
      ADDR_SECOND_ACCUMULATOR: cur = state.second_accumulator;
      default: cur = RST_ZERO; // Unoccupied reads return zero
    endcase
    upd = cur;
    if (req.bit_mode) begin
      upd[bit_pos] = req.wdata[0]; // RULE2
    end else begin
      upd = req.wdata;
    end
  end

  // -----------------------------------------------------------------
  // State update
  // -----------------------------------------------------------------
  always_comb begin
    next_state = state;
    next_state.rsp.rvalid = 1'b0;
    next_state.rsp.to_sfr = 1'b0;
    next_state.rsp.to_upper_ram = 1'b0;
    next_state.rsp.ram_addr = RST_ZERO;
    if (req.op != SFD_NONE) begin
      next_state.rsp.to_sfr = in_sfr; // RULE1
      next_state.rsp.to_upper_ram = req.indirect && req.addr[7]; // RULE9
      next_state.rsp.ram_addr = req.addr;
    end
    if (req.op == SFD_READ) begin
      next_state.rsp.rvalid = 1'b1;
      next_state.rsp.rdata = valid_acc ?
        (req.bit_mode ? {7'h00, cur[bit_pos]} : cur) : RST_ZERO;
    end
    // Writes to unoccupied addresses are dropped; the core must avoid them
    if (req.op == SFD_WRITE && valid_acc) begin // RULE4
      unique case (byte_addr)
        ADDR_STACK_POINTER: next_state.stack_pointer = upd;
        ADDR_DATA_POINTER_LOW: next_state.data_pointer_low = upd; // RULE6
        ADDR_DATA_POINTER_HIGH: next_state.data_pointer_high = upd; // RULE7
        ADDR_STATUS_WORD: next_state.program_status_word = upd;
        ADDR_ACCUMULATOR: next_state.accumulator = upd;
        // Only the second accumulator is left once valid_acc holds
        default: next_state.second_accumulator = upd;
      endcase
    end
    // Push increments first so the pointer names the last used entry
    if (req.push) begin
      next_state.stack_pointer = state.stack_pointer + 8'h01; // RULE10
      next_state.rsp.ram_addr = state.stack_pointer + 8'h01;
    end
    // Parity bit is read-only and follows the accumulator
    parity = ^next_state.accumulator;
    next_state.program_status_word[STATUS_PARITY_BIT] = parity;
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      state <= '0; // RULE5
      state.stack_pointer <= RST_STACK_POINTER; // RULE10
      state.data_pointer_low <= RST_ZERO; // RULE6
      state.data_pointer_high <= RST_ZERO; // RULE7
    end else begin
      state <= next_state;
    end
  end

  assign rsp = state.rsp;
  assign data_pointer_16 = {state.data_pointer_high, state.data_pointer_low}; // RULE8
  assign stack_pointer = state.stack_pointer;

  // -----------------------------------------------------------------
  // Checks
  // -----------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);

  a_low_ptr_write: assert property ( // RULE6
    req.op == SFD_WRITE && !req.indirect && !req.bit_mode &&
    req.addr == ADDR_DATA_POINTER_LOW && !req.push
    |=> data_pointer_16[7:0] == $past(req.wdata))
    else $error("low pointer byte not written");

  a_high_ptr_write: assert property ( // RULE7
    req.op == SFD_WRITE && !req.indirect && !req.bit_mode &&
    req.addr == ADDR_DATA_POINTER_HIGH
    |=> data_pointer_16[15:8] == $past(req.wdata))
    else $error("high pointer byte not written");

  a_push_incr: assert property ( // RULE10
    req.push |=> stack_pointer == $past(stack_pointer) + 8'h01)
    else $error("push did not increment stack pointer");

  a_push_store: assert property ( // RULE10
    req.push |=> rsp.ram_addr == stack_pointer)
    else $error("push store address is not the new pointer");

  a_sp_byte_write: assert property ( // RULE3
    req.op == SFD_WRITE && !req.indirect && !req.bit_mode &&
    req.addr == ADDR_STACK_POINTER && !req.push
    |=> stack_pointer == $past(req.wdata))
    else $error("stack pointer byte not written");

  // -----------------------------------------------------------------
  // Routing checks
  // -----------------------------------------------------------------
  a_direct_route: assert property ( // RULE1
    req.op != SFD_NONE && !req.indirect && req.addr[7] && !req.bit_mode
    |=> rsp.to_sfr && !rsp.to_upper_ram)
    else $error("direct upper access not routed to registers");

  a_indirect_route: assert property ( // RULE9
    req.op != SFD_NONE && req.indirect && req.addr[7]
    |=> rsp.to_upper_ram && !rsp.to_sfr)
    else $error("indirect upper access not routed to RAM");

  a_lower_direct: assert property ( // RULE9
    req.op != SFD_NONE && !req.indirect && !req.addr[7]
    |=> !rsp.to_sfr && !rsp.to_upper_ram)
    else $error("lower direct access routed upward");

  a_read_answer: assert property ( // RULE1
    req.op == SFD_READ |=> rsp.rvalid)
    else $error("read not answered in one cycle");

  a_idle_quiet: assert property ( // RULE1
    req.op == SFD_NONE && !req.push
    |=> !rsp.rvalid && !rsp.to_sfr && !rsp.to_upper_ram)
    else $error("response pulse without request");

  // -----------------------------------------------------------------
  // Bit access checks, then byte write, reserved read, pointer and reset checks
  // -----------------------------------------------------------------
  // Bit writes to 0x80-0x87 must leave the stack pointer and data pointer untouched
  a_bit_reject: assert property ( // RULE3
    req.op == SFD_WRITE && req.bit_mode && req.addr[7] &&
    !req.indirect && req.addr[7:3] == 5'h10 && !req.push
    |=> $stable(stack_pointer) && $stable(data_pointer_16))
    else $error("bit write touched byte-only register");

  a_bit_read: assert property ( // RULE2 RULE11
    req.op == SFD_READ && req.bit_mode && !req.indirect && req.addr[7:3] == 5'h1C
    |=> rsp.rdata == {7'h00, $past(state.accumulator[req.addr[2:0]])})
    else $error("bit read returned wrong value");

  a_bit_write: assert property ( // RULE2 RULE11
    req.op == SFD_WRITE && req.bit_mode && !req.indirect && req.addr[7:3] == 5'h1C
    |=> state.accumulator ==
      (($past(state.accumulator) & ~(8'h01 << $past(req.addr[2:0]))) |
       ({7'h00, $past(req.wdata[0])} << $past(req.addr[2:0]))))
    else $error("bit write changed wrong accumulator bits");

  a_second_write: assert property ( // RULE2
    req.op == SFD_WRITE && !req.indirect && !req.bit_mode &&
    req.addr == ADDR_SECOND_ACCUMULATOR
    |=> state.second_accumulator == $past(req.wdata))
    else $error("second accumulator byte not written");

  a_reserved_read: assert property ( // RULE4
    req.op == SFD_READ && !req.bit_mode && !req.indirect && req.addr == 8'h84
    |=> rsp.rdata == 8'h00)
    else $error("reserved address read nonzero");

  a_ptr_stable: assert property ( // RULE8
    req.op != SFD_WRITE && !req.push |=> $stable(data_pointer_16) [*1])
    else $error("data pointer changed without write");

  a_reset_zero: assert property ( // RULE5
    $fell(reset) |-> data_pointer_16 == 16'h0000)
    else $error("pointer not zero after reset");

  c_push: cover property (req.push ##1 req.push);
  c_bit_write: cover property (req.op == SFD_WRITE && req.bit_mode && valid_acc);
  c_indirect: cover property (req.op == SFD_READ && req.indirect && req.addr[7]);
  c_ptr_pair: cover property (req.op == SFD_WRITE && req.addr == ADDR_DATA_POINTER_HIGH ##1
    req.op == SFD_WRITE && req.addr == ADDR_DATA_POINTER_LOW);
  c_reserved: cover property (req.op == SFD_READ && in_sfr && !occupied(byte_addr));
endmodule
`default_nettype wire

// [sfd_pkg.sv]
// Package for the special function register space decoder
`default_nettype none
package sfd_pkg;
  localparam logic [7:0] SFR_BASE = 8'h80;
  localparam logic [7:0] ADDR_STACK_POINTER = 8'h81;
  localparam logic [7:0] ADDR_DATA_POINTER_LOW = 8'h82;
  localparam logic [7:0] ADDR_DATA_POINTER_HIGH = 8'h83;
  localparam logic [7:0] ADDR_STATUS_WORD = 8'hD0;
  localparam logic [7:0] ADDR_ACCUMULATOR = 8'hE0;
  localparam logic [7:0] ADDR_SECOND_ACCUMULATOR = 8'hF0;
  localparam logic [7:0] RST_STACK_POINTER = 8'h07;
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam int STATUS_PARITY_BIT = 0;

  typedef enum logic [1:0] {SFD_NONE, SFD_READ, SFD_WRITE} sfd_op_t;

  // One access from the core
  typedef struct packed {
    sfd_op_t op;
    logic indirect;
    logic bit_mode;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic push;
  } sfd_req_t;

  typedef struct packed {
    logic [7:0] rdata;
    logic rvalid;
    logic to_sfr;
    logic to_upper_ram;
    logic [7:0] ram_addr;
  } sfd_rsp_t;

  typedef struct packed {
    logic [7:0] stack_pointer;
    logic [7:0] data_pointer_low;
    logic [7:0] data_pointer_high;
    logic [7:0] program_status_word;
    logic [7:0] accumulator;
    logic [7:0] second_accumulator;
    sfd_rsp_t rsp;
  } sfd_state_t;
endpackage
`default_nettype wire

// [sfd_core_model.sv]
// Core-side model that issues accesses into the register space
`default_nettype none
module sfd_core_model
  import sfd_pkg::*;
(
  input wire logic clock,
  output sfd_pkg::sfd_req_t req
);
  timeunit 1ns;
  timeprecision 1ps;
  initial req = '0;
  // One request per call, held for exactly one taking edge
  // Address and data are inverted after release so stale values never look valid
  task automatic access(input sfd_op_t op, input logic ind, input logic bm,
                        input logic [7:0] a, input logic [7:0] d, input logic psh);
    @(posedge clock);
    req <= '{op, ind, bm, a, d, psh};
    @(posedge clock);
    req <= '{SFD_NONE, 1'b0, 1'b0, ~a, ~d, 1'b0};
    #1;
  endtask
endmodule
`default_nettype wire

// [sfd_space_tb.sv]
// Self-checking bench for the register space decoder
`default_nettype none
module sfd_space_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import sfd_pkg::*;
  logic clock = 1'b0;
  logic reset = 1'b1;
  sfd_req_t req;
  sfd_rsp_t rsp;
  logic [15:0] dp;
  logic [7:0] stack_seen;
  int n_errors = 0;
  int num_checks = 0;
  sfd_core_model core (.clock(clock), .req(req));
  sfd_space dut (.clock(clock), .reset(reset), .req(req), .rsp(rsp),
    .data_pointer_16(dp), .stack_pointer(stack_seen));
  initial begin
    forever #4 clock = ~clock;
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // Mode bits are {indirect, bit access, push}
  task automatic a(input sfd_op_t op, input logic [2:0] m, input logic [7:0] ad,
                   input logic [7:0] d);
    core.access(op, m[2], m[1], ad, d, m[0]);
  endtask
  task automatic wrap_up();
    $display("checks=%0d errors=%0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic t_reset();
    check({8'h00, stack_seen}, 16'h0007);
    check(dp, 16'h0000);
    a(SFD_READ, 3'b000, ADDR_DATA_POINTER_HIGH, 8'h00);
    check({rsp.rvalid, 7'h00, rsp.rdata}, 16'h8000);
    $display("t_reset done");
  endtask
  task automatic t_data_pointer_16();
    a(SFD_WRITE, 3'b000, ADDR_DATA_POINTER_LOW, 8'h5A);
    a(SFD_WRITE, 3'b000, ADDR_DATA_POINTER_HIGH, 8'hC3);
    check(dp, 16'hC35A);
    a(SFD_READ, 3'b000, ADDR_DATA_POINTER_LOW, 8'h00);
    check({6'h00, rsp.rvalid, rsp.to_sfr, rsp.rdata}, 16'h035A);
    a(SFD_READ, 3'b000, ADDR_DATA_POINTER_HIGH, 8'h00);
    check({8'h00, rsp.rdata}, 16'h00C3);
    $display("t_data_pointer_16 done");
  endtask
  task automatic t_bits();
    a(SFD_WRITE, 3'b000, ADDR_ACCUMULATOR, 8'h00);
    a(SFD_WRITE, 3'b010, 8'hE3, 8'h01);
    a(SFD_READ, 3'b000, ADDR_ACCUMULATOR, 8'h00);
    check({8'h00, rsp.rdata}, 16'h0008);
    a(SFD_READ, 3'b010, 8'hE3, 8'h00);
    check({8'h00, rsp.rdata}, 16'h0001);
    a(SFD_WRITE, 3'b010, 8'h82, 8'h01);
    check(dp, 16'hC35A);
    $display("t_bits done");
  endtask
  task automatic t_route();
    a(SFD_READ, 3'b100, 8'h90, 8'h00);
    check({6'h00, rsp.to_upper_ram, rsp.to_sfr, rsp.rdata}, 16'h0200);
    a(SFD_READ, 3'b000, 8'h7F, 8'h00);
    check({15'h0000, rsp.to_sfr}, 16'h0000);
    a(SFD_READ, 3'b000, 8'h84, 8'h00);
    check({7'h00, rsp.to_sfr, rsp.rdata}, 16'h0100);
    a(SFD_WRITE, 3'b000, ADDR_STACK_POINTER, 8'h20);
    a(SFD_NONE, 3'b001, 8'h00, 8'h00);
    check({stack_seen, rsp.ram_addr}, 16'h2121);
    $display("t_route done");
  endtask
  initial begin
    repeat (3) @(posedge clock);
    reset <= 1'b0;
    t_reset();
    t_data_pointer_16();
    t_bits();
    t_route();
    wrap_up();
  end
  // 15 accesses of two cycles each; this leaves ample margin
  initial begin
    #20000;
    n_errors++;
    wrap_up();
  end
endmodule
`default_nettype wire
